// ### hdl/sidr_pkg.sv
// Purpose: constants and carrier types for the status, event and debug
//          register block.
// Assumes: 32-bit register data, byte offsets as printed.
// Notes:   every offset, field position and reset value is named here once.

package sidr_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ENGINE_STATUS = 8'h24;
	localparam logic [7:0] OFS_RAW_EVENT = 8'h28;
	localparam logic [7:0] OFS_COMBINED_EVENT = 8'h2C;
	localparam logic [7:0] OFS_EVENT_ENABLE_MASK = 8'h30;
	localparam logic [7:0] OFS_DEBUG_SELECT = 8'h34;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_ENGINE_STATUS = 32'h0000_0000;
	localparam logic [31:0] RST_RAW_EVENT = 32'h0000_0000;
	localparam logic [31:0] RST_COMBINED_EVENT = 32'h0000_0000;
	localparam logic [31:0] RST_EVENT_ENABLE_MASK = 32'h0000_0000;
	localparam logic [7:0] RST_DEBUG_SELECT = 8'h00;
	localparam logic [31:0] RST_READ_DATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// raw event status / clear bit positions
	// ----------------------------------------------------------------
	localparam int RAW_VIDEO_PORT1 = 6;
	localparam int RAW_VIDEO_PORT0 = 4;
	localparam int RAW_CRT_VSYNC = 3;
	localparam int RAW_PANEL_VSYNC = 1;
	localparam int RAW_CMD_INTERP = 0;
	localparam int RAW_SOURCES = 5;

	// ----------------------------------------------------------------
	// combined status and mask bit positions
	// ----------------------------------------------------------------
	localparam int CMB_GPIO54 = 30;
	localparam int CMB_PULSE_MOD = 22;
	localparam int CMB_DMA = 20;
	localparam int CMB_PCI = 19;
	localparam int CMB_CRT_VSYNC = 11;
	localparam int CMB_VIDEO_PORT1 = 4;
	localparam int CMB_DRAWING_ENGINE = 3;
	localparam int CMB_VIDEO_PORT0 = 2;
	localparam int CMB_PANEL_VSYNC = 1;
	localparam int CMB_CMD_INTERP = 0;
	localparam logic [31:0] MASK_WRITABLE = 32'h405C_081F;

	// ----------------------------------------------------------------
	// engine status bit positions
	// ----------------------------------------------------------------
	localparam int ENG_MEM2D_EMPTY = 20;
	localparam int ENG_HIF_CMD_EMPTY = 19;
	localparam int ENG_CSC_BUSY = 18;
	localparam int ENG_DMA_BUSY = 17;
	localparam int ENG_CRT_FLIP = 16;
	localparam int ENG_VIDEO_FIELD = 15;
	localparam int ENG_VIDEO_FLIP = 14;
	localparam int ENG_PANEL_FLIP = 13;
	localparam int ENG_CRT_VSYNC = 12;
	localparam int ENG_PANEL_VSYNC = 11;
	localparam int ENG_SETUP_BUSY = 2;
	localparam int ENG_CMD_EMPTY = 1;
	localparam int ENG_ENGINE_BUSY = 0;

	// ----------------------------------------------------------------
	// debug select fields and partition codes
	// ----------------------------------------------------------------
	localparam int DBG_PART_LSB = 0;
	localparam int DBG_PART_W = 5;
	localparam int DBG_MOD_LSB = 5;
	localparam int DBG_MOD_W = 3;
	localparam int DBG_W = 8;
	localparam logic [4:0] PART_HOST_INTERFACE = 5'h00;
	localparam logic [4:0] PART_PCI = 5'h02;
	localparam logic [4:0] PART_CMD_INTERP = 5'h03;
	localparam logic [4:0] PART_DISPLAY = 5'h04;
	localparam logic [4:0] PART_VIDEO_PORT = 5'h05;
	localparam logic [4:0] PART_DRAWING_ENGINE = 5'h06;
	localparam logic [4:0] PART_LOCAL_MEM_IF = 5'h08;
	localparam logic [4:0] PART_LOCAL_MEM_CTRL = 5'h1A;
	localparam logic [4:0] PART_DMA = 5'h1B;
	localparam logic [4:0] PART_SIM_TEST = 5'h1C;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	// one-cycle pulses that latch into the raw event register
	typedef struct packed {
		logic video_port1_event;
		logic video_port0_event;
		logic crt_vsync_event;
		logic panel_vsync_event;
		logic cmd_interp_event;
	} sidr_raw_ev_t;

	// level requests held by their own units until serviced there
	typedef struct packed {
		logic gpio54_event;
		logic pulse_mod_event;
		logic dma_event;
		logic pci_event;
		logic drawing_engine_event;
	} sidr_lvl_ev_t;

	typedef struct packed {
		logic mem2d_queue_empty;
		logic hif_cmd_queue_empty;
		logic csc_busy;
		logic dma_busy;
		logic crt_flip;
		logic video_field_even;
		logic video_flip;
		logic panel_flip;
		logic crt_vsync_active;
		logic panel_vsync_active;
		logic setup_busy;
		logic cmd_queue_empty;
		logic engine_busy;
	} sidr_engine_t;

endpackage : sidr_pkg

// ### hdl/sidr_sticky_bits.sv
// Purpose: bank of sticky event bits, set by pulses, cleared by a mask.
// Assumes: set and clear are synchronous one-cycle strobes.
// Notes:   a set in the clearing cycle wins.

`timescale 1ns/1ps

module sidr_sticky_bits #(
	parameter int WIDTH = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clr,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] next_q;

	// ----------------------------------------------------------------
	// next state, one slice per bit
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_comb begin
			// losing an event is worse than a spurious re-read
			next_q[i] = set[i] | (q[i] & ~clr[i]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

endmodule : sidr_sticky_bits

// ### hdl/sidr_top.sv
// Purpose: status, event latching, event masking and debug select
//          registers of the host interface, with the request output.
// Assumes: registers reached over the host interface register port with
//          byte offsets; one clock; all inputs synchronous to clk.
// Notes:   reads answer one cycle after the strobe; unmapped reads give 0.
//          writes to read-only or unmapped offsets are dropped.
//          a raw event reaches the request line on its third edge.
//          engine status reads back a snapshot one cycle old.
//          debug select keeps bits 7:0; partition codes are not checked.
//          the request line is low throughout reset, whatever the polarity.
//
// Functional notes
// - raw event bits clear only where a one is written; zeros keep bits
// - raw bits: port1 at 6, port0 at 4, crt vsync 3, panel 1, cmd 0
// - a write to the raw event offset is a clear command, not a store
// - combined: gpio54 at 30, pulse mod 22, dma 20, pci 19, read-only
// - combined: crt vsync 11, port1 4, drawing 3, port0 2, panel 1, cmd 0
// - mask holds one enable per combined bit, same position, one enables
// - raw, combined and mask registers reset to zero
// - five-bit partition field picks the unit observed in debug mode
// - three-bit module field at 7:5; debug select resets to zero
// - engine status: setup busy 2, command queue empty 1, engine busy 0
// - engine status: crt vsync active at 12, panel vsync active at 11
// - engine status: crt flip 16, video flip 14, panel flip 13
// - engine status bit 15 shows field, zero odd, one even
// - engine status: 2d memory queue empty 20, host command queue 19
// - engine status: color conversion busy 18, memory dma busy 17
// - request polarity normal when invert bit zero, inverted when one

`timescale 1ns/1ps

module sidr_top
	import sidr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire sidr_raw_ev_t raw_events,
	input wire sidr_lvl_ev_t level_events,
	input wire sidr_engine_t engine,
	input wire logic irq_polarity_invert,
	output logic irq,
	output logic [DBG_PART_W-1:0] debug_partition,
	output logic [DBG_MOD_W-1:0] debug_module
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic hit_engine;
	logic hit_raw;
	logic hit_combined;
	logic hit_mask;
	logic hit_debug;

	always_comb begin
		hit_engine = (reg_addr == ADDR_W'(OFS_ENGINE_STATUS));
		hit_raw = (reg_addr == ADDR_W'(OFS_RAW_EVENT));
		hit_combined = (reg_addr == ADDR_W'(OFS_COMBINED_EVENT));
		hit_mask = (reg_addr == ADDR_W'(OFS_EVENT_ENABLE_MASK));
		hit_debug = (reg_addr == ADDR_W'(OFS_DEBUG_SELECT));
	end

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	logic wr_raw;
	logic wr_mask;
	logic wr_debug;

	// read-only and unmapped offsets match none of these, so drop out
	always_comb begin
		wr_raw = reg_wr && hit_raw;
		wr_mask = reg_wr && hit_mask;
		wr_debug = reg_wr && hit_debug;
	end

	// ----------------------------------------------------------------
	// raw event latch
	// ----------------------------------------------------------------
	logic [RAW_SOURCES-1:0] raw_set;
	logic [RAW_SOURCES-1:0] raw_clr;
	logic [RAW_SOURCES-1:0] raw_q;
	logic [31:0] raw_word;

	// source order inside the latch follows the struct, msb first
	always_comb begin
		raw_set = raw_events;
		raw_clr = '0;
		if (wr_raw) begin
			// only ones clear; zero bits leave the latch alone
			raw_clr[4] = reg_wdata[RAW_VIDEO_PORT1];
			raw_clr[3] = reg_wdata[RAW_VIDEO_PORT0];
			raw_clr[2] = reg_wdata[RAW_CRT_VSYNC];
			raw_clr[1] = reg_wdata[RAW_PANEL_VSYNC];
			raw_clr[0] = reg_wdata[RAW_CMD_INTERP];
		end
	end

	sidr_sticky_bits #(
		.WIDTH(RAW_SOURCES)
	) u_raw_latch (
		.clk(clk),
		.rst(rst),
		.set(raw_set),
		.clr(raw_clr),
		.q(raw_q)
	);

	always_comb begin
		raw_word = RST_RAW_EVENT;
		raw_word[RAW_VIDEO_PORT1] = raw_q[4];
		raw_word[RAW_VIDEO_PORT0] = raw_q[3];
		raw_word[RAW_CRT_VSYNC] = raw_q[2];
		raw_word[RAW_PANEL_VSYNC] = raw_q[1];
		raw_word[RAW_CMD_INTERP] = raw_q[0];
	end

	// ----------------------------------------------------------------
	// combined status and mask
	// ----------------------------------------------------------------
	logic [31:0] combined;
	logic [31:0] next_combined;
	logic [31:0] mask;
	logic [31:0] next_mask;

	always_comb begin
		next_combined = RST_COMBINED_EVENT;
		next_combined[CMB_GPIO54] = level_events.gpio54_event;
		next_combined[CMB_PULSE_MOD] = level_events.pulse_mod_event;
		next_combined[CMB_DMA] = level_events.dma_event;
		next_combined[CMB_PCI] = level_events.pci_event;
		next_combined[CMB_CRT_VSYNC] = raw_q[2];
		next_combined[CMB_VIDEO_PORT1] = raw_q[4];
		next_combined[CMB_DRAWING_ENGINE] =
			level_events.drawing_engine_event;
		next_combined[CMB_VIDEO_PORT0] = raw_q[3];
		next_combined[CMB_PANEL_VSYNC] = raw_q[1];
		next_combined[CMB_CMD_INTERP] = raw_q[0];
	end

	always_comb begin
		next_mask = mask;
		if (wr_mask) begin
			// only the combined positions and bit 18 store; bit 18 has no source, so it never enables
			next_mask = reg_wdata & MASK_WRITABLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			combined <= RST_COMBINED_EVENT;
			mask <= RST_EVENT_ENABLE_MASK;
		end else begin
			combined <= next_combined;
			mask <= next_mask;
		end
	end

	// ----------------------------------------------------------------
	// request output
	// ----------------------------------------------------------------
	logic next_irq;
	logic pending;
	logic [31:0] enabled;

	// per-source gate; reserved combined bits are zero, so their slots stay low
	for (genvar i = 0; i < 32; i++) begin : g_gate
		always_comb begin
			enabled[i] = combined[i] & mask[i];
		end
	end

	always_comb begin
		pending = |enabled;
		// polarity applies after the gate so masking stays intuitive
		next_irq = pending ^ irq_polarity_invert;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// debug select
	// ----------------------------------------------------------------
	logic [DBG_W-1:0] debug_select;
	logic [DBG_W-1:0] next_debug_select;

	always_comb begin
		next_debug_select = debug_select;
		if (wr_debug) begin
			// any code is stored; unlisted codes simply observe nothing
			next_debug_select = reg_wdata[DBG_W-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			debug_select <= RST_DEBUG_SELECT;
			debug_partition <= RST_DEBUG_SELECT[DBG_PART_W-1:0];
			debug_module <= RST_DEBUG_SELECT[DBG_W-1:DBG_MOD_LSB];
		end else begin
			debug_select <= next_debug_select;
			debug_partition <=
				next_debug_select[DBG_PART_LSB +: DBG_PART_W];
			debug_module <=
				next_debug_select[DBG_MOD_LSB +: DBG_MOD_W];
		end
	end

	// ----------------------------------------------------------------
	// engine status snapshot
	// ----------------------------------------------------------------
	logic [31:0] engine_word;
	logic [31:0] next_engine_word;

	always_comb begin
		next_engine_word = RST_ENGINE_STATUS;
		next_engine_word[ENG_MEM2D_EMPTY] =
			engine.mem2d_queue_empty;
		next_engine_word[ENG_HIF_CMD_EMPTY] =
			engine.hif_cmd_queue_empty;
		next_engine_word[ENG_CSC_BUSY] = engine.csc_busy;
		next_engine_word[ENG_DMA_BUSY] = engine.dma_busy;
		next_engine_word[ENG_CRT_FLIP] = engine.crt_flip;
		next_engine_word[ENG_VIDEO_FIELD] =
			engine.video_field_even;
		next_engine_word[ENG_VIDEO_FLIP] = engine.video_flip;
		next_engine_word[ENG_PANEL_FLIP] = engine.panel_flip;
		next_engine_word[ENG_CRT_VSYNC] =
			engine.crt_vsync_active;
		next_engine_word[ENG_PANEL_VSYNC] =
			engine.panel_vsync_active;
		next_engine_word[ENG_SETUP_BUSY] = engine.setup_busy;
		next_engine_word[ENG_CMD_EMPTY] =
			engine.cmd_queue_empty;
		next_engine_word[ENG_ENGINE_BUSY] = engine.engine_busy;
	end

	// snapshot costs a cycle of staleness but keeps the read path short
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			engine_word <= RST_ENGINE_STATUS;
		end else begin
			engine_word <= next_engine_word;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] read_word;
	logic [31:0] next_rdata;
	logic next_rvalid;

	// offsets are distinct, so the chain order never decides anything
	always_comb begin
		read_word = RST_READ_DATA;
		if (hit_engine) begin
			read_word = engine_word;
		end else if (hit_raw) begin
			read_word = raw_word;
		end else if (hit_combined) begin
			read_word = combined;
		end else if (hit_mask) begin
			read_word = mask;
		end else if (hit_debug) begin
			read_word = {{(32 - DBG_W){1'b0}}, debug_select};
		end
	end

	// data is forced to zero between reads so stale words never linger
	always_comb begin
		next_rvalid = reg_rd;
		next_rdata = RST_READ_DATA;
		if (reg_rd) begin
			next_rdata = read_word;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= RST_READ_DATA;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

endmodule : sidr_top

// ### verification/sidr_checker.sv
// Purpose: port assertions for the status, event and debug registers.
// Assumes: one clock, reset high and asynchronous.
// Notes:   reads answer one cycle after the strobe.
`timescale 1ns/1ps
module sidr_checker
	import sidr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire sidr_raw_ev_t raw_events,
	input wire sidr_lvl_ev_t level_events,
	input wire sidr_engine_t engine,
	input wire logic irq_polarity_invert,
	input wire logic irq,
	input wire logic [DBG_PART_W-1:0] debug_partition,
	input wire logic [DBG_MOD_W-1:0] debug_module
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_timing: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered after one cycle");
	a_idle_data: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 0)
		else $error("read data or valid without a read");
	a_mask_store: assert property (
		(reg_wr && reg_addr == OFS_EVENT_ENABLE_MASK) ##1 !reg_wr ##1
		(reg_rd && reg_addr == OFS_EVENT_ENABLE_MASK)
		|=> reg_rdata == ($past(reg_wdata, 3) & MASK_WRITABLE))
		else $error("mask read back differs from stored bits");
	// a write one cycle earlier may legally clear, so it is excluded
	a_raw_latch: assert property (
		(reg_rd && reg_addr == OFS_RAW_EVENT && !$past(reg_wr))
		|=> (reg_rdata[31:7] == 0) && !reg_rdata[5] && !reg_rdata[2] &&
		((~{reg_rdata[6], reg_rdata[4:3], reg_rdata[1:0]} &
		($past(raw_events, 2) | $past(raw_events, 3))) == 5'h00))
		else $error("raw event lost or reserved bit set");
	a_clear_one: assert property (
		(reg_wr && reg_addr == OFS_RAW_EVENT && raw_events == 0) ##1
		(!reg_wr && raw_events == 0) ##1 (reg_rd && reg_addr == OFS_RAW_EVENT)
		|=> (reg_rdata[6:0] & $past(reg_wdata[6:0], 3)) == 7'h00)
		else $error("raw bit survived a clear");
	a_combined_live: assert property (
		(reg_rd && reg_addr == OFS_COMBINED_EVENT && $stable(level_events) &&
		level_events == $past(level_events, 2))
		|=> {reg_rdata[30], reg_rdata[22], reg_rdata[20:19], reg_rdata[3]}
		== $past(level_events))
		else $error("combined level bits wrong");
	a_engine_map: assert property (
		(reg_rd && reg_addr == OFS_ENGINE_STATUS && $stable(engine))
		|=> reg_rdata == {11'h000, $past(engine[12:3]), 8'h00,
		$past(engine[2:0])})
		else $error("engine status layout wrong");
	a_debug_fields: assert property (
		(reg_wr && reg_addr == OFS_DEBUG_SELECT) |=>
		(debug_partition == $past(reg_wdata[4:0]) &&
		debug_module == $past(reg_wdata[7:5])))
		else $error("debug fields do not follow the write");
	a_debug_hold: assert property (
		!(reg_wr && reg_addr == OFS_DEBUG_SELECT) [*3]
		|=> $stable(debug_partition) && $stable(debug_module))
		else $error("debug fields moved without a write");
	a_irq_polarity: assert property (
		($changed(irq_polarity_invert) && !$past(reg_wr) &&
		!$past(reg_wr, 2) && $past(raw_events, 2) == 0 &&
		$past(level_events) == $past(level_events, 2))
		|=> irq != $past(irq))
		else $error("request did not invert with polarity");
endmodule : sidr_checker

// ### verification/sidr_host_model.sv
// Purpose: host side of the request line.
// Assumes: host samples the line on clk.
// Notes:   decodes with the polarity it programmed.
`timescale 1ns/1ps
module sidr_host_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq,
	input wire logic irq_polarity_invert,
	output logic req_seen
);
	logic next_req_seen;
	always_comb begin
		next_req_seen = irq ^ irq_polarity_invert;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_seen <= 1'b0;
		end else begin
			req_seen <= next_req_seen;
		end
	end
endmodule : sidr_host_model

// ### verification/sidr_top_bench.sv
// Purpose: register-level tests of the status and event block.
// Assumes: reads answer one cycle after the strobe.
// Notes:   inputs change by non-blocking assignment on clk.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module sidr_top_bench
	import sidr_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic reg_rvalid, irq, req_seen, irq_polarity_invert = 1'b0;
	sidr_raw_ev_t raw_events = '0;
	sidr_lvl_ev_t level_events = '0;
	sidr_engine_t engine = '0;
	logic [4:0] debug_partition;
	logic [2:0] debug_module;
	int miscompares = 0, checks_done = 0, cycles = 0;
	int rp[5] = '{0, 1, 3, 4, 6};
	int cp[5] = '{0, 1, 11, 2, 4};
	int lp[5] = '{3, 19, 20, 22, 30};
	logic [7:0] regs[4] = '{OFS_RAW_EVENT, OFS_COMBINED_EVENT,
		OFS_EVENT_ENABLE_MASK, OFS_DEBUG_SELECT};
	logic [4:0] parts[10] = '{PART_HOST_INTERFACE, PART_PCI,
		PART_CMD_INTERP, PART_DISPLAY, PART_VIDEO_PORT, PART_DRAWING_ENGINE,
		PART_LOCAL_MEM_IF, PART_LOCAL_MEM_CTRL, PART_DMA, PART_SIM_TEST};
	logic [31:0] d;
	always #10 clk = ~clk;
	sidr_top #(.ADDR_W(8)) dut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata, .reg_rvalid, .raw_events, .level_events, .engine,
		.irq_polarity_invert, .irq, .debug_partition, .debug_module);
	sidr_host_model host (.clk, .rst, .irq, .irq_polarity_invert, .req_seen);
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("read valid", 1'b1, reg_rvalid)
		`CHK(n, e, reg_rdata)
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 32'h0000_0000, "reset value");
		`CHK("debug out", 8'h00, {debug_module, debug_partition})
		`CHK("irq idle", 1'b0, irq)
		rd(8'h38, 32'h0000_0000, "unmapped");
		wr(OFS_COMBINED_EVENT, 32'hFFFF_FFFF);
		rd(OFS_COMBINED_EVENT, 32'h0000_0000, "combined ro");
		wr(OFS_EVENT_ENABLE_MASK, 32'hFFFF_FFFF);
		rd(OFS_EVENT_ENABLE_MASK, MASK_WRITABLE, "mask");
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			raw_events <= 5'(1 << i);
			@(posedge clk);
			raw_events <= '0;
			rd(OFS_RAW_EVENT, 32'h1 << rp[i], "raw bit");
			rd(OFS_COMBINED_EVENT, 32'h1 << cp[i], "cmb bit");
			wr(OFS_EVENT_ENABLE_MASK, 32'h1 << cp[i]);
			wr(OFS_RAW_EVENT, ~(32'h1 << rp[i]));
			rd(OFS_RAW_EVENT, 32'h1 << rp[i], "zero keeps");
			`CHK("irq raw", 1'b1, irq)
			`CHK("host req", 1'b1, req_seen)
			wr(OFS_RAW_EVENT, 32'h1 << rp[i]);
			rd(OFS_RAW_EVENT, 32'h0000_0000, "cleared");
			idle(2);
			`CHK("irq off", 1'b0, irq)
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			level_events <= 5'(1 << i);
			wr(OFS_EVENT_ENABLE_MASK, 32'h0000_0000);
			rd(OFS_COMBINED_EVENT, 32'h1 << lp[i], "level bit");
			`CHK("irq masked", 1'b0, irq)
			wr(OFS_EVENT_ENABLE_MASK, 32'h1 << lp[i]);
			idle(2);
			`CHK("irq level", 1'b1, irq)
			@(posedge clk);
			irq_polarity_invert <= 1'b1;
			idle(2);
			`CHK("irq inverted", 1'b0, irq)
			`CHK("host inverted", 1'b1, req_seen)
			@(posedge clk);
			irq_polarity_invert <= 1'b0;
			level_events <= '0;
			idle(4);
			`CHK("irq level off", 1'b0, irq)
		end
		@(posedge clk);
		raw_events <= 5'h04;
		reg_wr <= 1'b1;
		reg_addr <= OFS_RAW_EVENT;
		reg_wdata <= 32'h0000_0008;
		@(posedge clk);
		raw_events <= '0;
		reg_wr <= 1'b0;
		rd(OFS_RAW_EVENT, 32'h0000_0008, "set wins");
		for (int i = 0; i < 13; i++) begin
			@(posedge clk);
			engine <= 13'(1 << i);
			rd(OFS_ENGINE_STATUS, (i < 3) ? 32'h1 << i : 32'h1 << (i + 8),
				"engine bit");
		end
		foreach (parts[i]) begin
			d = {24'hFFFFFF, 3'(i), parts[i]};
			wr(OFS_DEBUG_SELECT, d);
			rd(OFS_DEBUG_SELECT, {24'h000000, d[7:0]}, "debug");
			`CHK("debug out", d[7:0], {debug_module, debug_partition})
		end
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 32'h0000_0000, "rerun reset");
		`CHK("irq reset", 1'b0, irq)
		results();
	end
endmodule : sidr_top_bench
bind sidr_top sidr_checker #(.ADDR_W(ADDR_W)) chk (.clk, .rst, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .raw_events,
	.level_events, .engine, .irq_polarity_invert, .irq, .debug_partition,
	.debug_module);
